// File: inc/isc_pkg.sv
// constants, register map and state type of the i2c slave control block
//
// Behaviour
// - bit 14 gates slave transmit dma requests
// - bit 13 gates slave receive dma requests
// - bit 12 lets restart flag raise interrupt
// - bit 10 lets transmit request raise interrupt
// - bit 9 lets receive request raise interrupt
// - bit 8 lets stop detection raise interrupt
// - bit 7 set: next acknowledge slot nacked
// - bit 5: transmit request at direction rise
// - restart flag: restart while matched; clears
// - stop flag: stop after matched start
package isc_pkg;

  // ****************************************************
  // bus and register map
  // ****************************************************
  localparam int unsigned ISC_AW = 32;                 // address width
  localparam int unsigned ISC_DW = 16;                 // register width
  localparam logic [31:0] ISC_OFS_CTL  = 32'h40003428; // slave_control
  localparam logic [31:0] ISC_OFS_STA  = 32'h4000342C; // slave status
  localparam logic [31:0] ISC_OFS_MSK  = 32'h40003430; // interrupt mask
  localparam logic [31:0] ISC_OFS_ADR  = 32'h40003434; // own 7-bit address
  localparam logic [31:0] ISC_OFS_TXD  = 32'h40003438; // transmit byte
  localparam logic [31:0] ISC_OFS_RXD  = 32'h4000343C; // received byte

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [15:0] ISC_RST_CTL = 16'h0000;
  localparam logic [15:0] ISC_RST_MSK = 16'h0000;
  localparam logic [6:0]  ISC_RST_ADR = 7'h00;
  localparam logic [7:0]  ISC_RST_TXD = 8'h00;
  localparam logic [15:0] ISC_CTL_WMASK = 16'h7FEF;   // bit 15 read-only, bit 4 read-only

  // ****************************************************
  // control field positions
  // ****************************************************
  localparam int unsigned ISC_C_TXDMA = 14;
  localparam int unsigned ISC_C_RXDMA = 13;
  localparam int unsigned ISC_C_IREP  = 12;
  localparam int unsigned ISC_C_ITX   = 10;
  localparam int unsigned ISC_C_IRX   = 9;
  localparam int unsigned ISC_C_ISTP  = 8;
  localparam int unsigned ISC_C_NACK  = 7;
  localparam int unsigned ISC_C_EARLY = 5;
  localparam int unsigned ISC_C_EN    = 0;

  // ****************************************************
  // status field positions (mask register shares them)
  // ****************************************************
  localparam int unsigned ISC_S_START = 14;
  localparam int unsigned ISC_S_REP   = 13;
  localparam int unsigned ISC_S_STOP  = 10;
  localparam int unsigned ISC_S_RXREQ = 3;
  localparam int unsigned ISC_S_TXREQ = 2;

  // ****************************************************
  // link timing
  // ****************************************************
  localparam int unsigned ISC_BITS_PER_BYTE = 8;

  // slave bit-level states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RXB, ST_TXB, ST_TACK, ST_SKIP
  } isc_state_e;

endpackage : isc_pkg

// File: inc/isc_evt_if.sv
// line events passed from the pin watcher to the slave core
`timescale 1ns/1ps
interface isc_evt_if;
  logic scl_rise;  // serial clock rose
  logic scl_fall;  // serial clock fell
  logic start;     // start or repeated start
  logic stop;      // stop condition
  logic sda;       // synchronised data level

  modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport snk (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : isc_evt_if

// File: verilog/isc_line_watch.sv
// pin synchroniser and bus condition detector
`timescale 1ns/1ps
module isc_line_watch (
  input  wire logic i_clk,     // core clock
  input  wire logic i_resetn,  // async reset, active low
  input  wire logic i_scl,     // serial clock pin
  input  wire logic i_sda,     // serial data pin
  isc_evt_if.src    evt        // decoded events
);
  import isc_pkg::*;

  logic [1:0] scl_meta_q;  // stage 0 read only by stage 1
  logic [1:0] sda_meta_q;
  logic       scl_old_q;   // previous synchronised level
  logic       sda_old_q;

  // ****************************************************
  // two-flop synchronisers; idle bus is high
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
    end else begin
      scl_meta_q <= {scl_meta_q[0], i_scl};
      sda_meta_q <= {sda_meta_q[0], i_sda};
    end
  end

  // history stage for edge finding, fed only from stage 1
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
    end else begin
      scl_old_q <= scl_meta_q[1];
      sda_old_q <= sda_meta_q[1];
    end
  end

  // ****************************************************
  // events: data moving while clock stays high is a condition
  // ****************************************************
  assign evt.scl_rise = scl_meta_q[1] & ~scl_old_q;
  assign evt.scl_fall = ~scl_meta_q[1] & scl_old_q;
  assign evt.start    = scl_meta_q[1] & scl_old_q & sda_old_q & ~sda_meta_q[1];
  assign evt.stop     = scl_meta_q[1] & scl_old_q & ~sda_old_q & sda_meta_q[1];
  assign evt.sda      = sda_meta_q[1];

endmodule : isc_line_watch

// File: verilog/isc_slave_ctrl.sv
// i2c slave core with control, status, mask and data registers
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module isc_slave_ctrl (
  input  wire logic                        i_clk,       // core clock, 250 MHz
  input  wire logic                        i_resetn,    // async reset, active low
  input  wire logic [isc_pkg::ISC_AW-1:0]  i_addr,      // register byte address
  input  wire logic [isc_pkg::ISC_DW-1:0]  i_wdata,     // write data
  input  wire logic                        i_wr,        // write strobe
  input  wire logic                        i_rd,        // read strobe
  output logic      [isc_pkg::ISC_DW-1:0]  o_rdata,     // read data, cycle after i_rd
  input  wire logic                        i_scl,       // serial clock pin
  input  wire logic                        i_sda,       // serial data pin input
  output logic                             o_sda,       // serial data pin output
  output logic                             o_sda_oe,    // high while pulling data low
  output logic                             o_irq,       // slave interrupt, level
  output logic                             o_tx_dma_req, // transmit dma request
  output logic                             o_rx_dma_req  // receive dma request
);
  import isc_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  isc_evt_if  evt ();            // line events
  isc_state_e state_q;           // bit-level state
  logic [2:0] cnt_q;             // bit counter in a byte
  logic [7:0] sh_q;              // shift register
  logic       rw_q;              // direction of current transfer
  logic       ack_q;             // we acknowledge this slot
  logic       ackph_q;           // second half of acknowledge slot
  logic       mack_q;            // master acked our byte
  logic       oe_q;              // pulling data line low
  logic       sda_q;             // data output level, always low
  logic [15:0] ctl_q;            // slave_control
  logic [15:0] msk_q;            // interrupt mask
  logic [6:0] adr_q;             // own address
  logic [7:0] txd_q;             // byte to send
  logic [7:0] rxd_q;             // last byte received
  logic       match_q;           // start with matching address seen
  logic       rep_q;             // restart_seen_flag
  logic       stp_q;             // stop flag
  logic       txr_q;             // transmit request pending
  logic       rxr_q;             // receive request pending
  logic [15:0] rd_q;             // read data register
  logic       irq_q;
  logic       txdma_q;
  logic       rxdma_q;
  logic       bus_on;            // slave enabled
  logic       addr_done;         // eighth address bit sampled
  logic       addr_hit;          // address matches ours
  logic       rx_done;           // eighth data bit received
  logic       tx_load;           // shifter loaded with next byte
  logic       ev_rep;            // restart while matched
  logic       ev_stp;            // stop while matched
  logic       rd_sta;            // status read this cycle
  logic [15:0] sta_c;            // assembled status
  logic [15:0] en_c;             // control enables at status positions

  isc_line_watch u_watch (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_scl    (i_scl),
    .i_sda    (i_sda),
    .evt      (evt)
  );

  // decode: is this address selected by a strobe
  function automatic logic hit(input logic [ISC_AW-1:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************************
  // event terms shared by several processes
  // ****************************************************
  assign bus_on    = ctl_q[ISC_C_EN];
  assign addr_done = (state_q == ST_ADDR) && evt.scl_rise && (cnt_q == 3'(ISC_BITS_PER_BYTE - 1));
  assign addr_hit  = (sh_q[6:0] == adr_q);
  assign rx_done   = (state_q == ST_RXB) && evt.scl_rise && (cnt_q == 3'(ISC_BITS_PER_BYTE - 1));
  assign tx_load   = (state_q == ST_ACK) && evt.scl_fall && ackph_q && ack_q && rw_q
                   || (state_q == ST_TACK) && evt.scl_fall && mack_q;
  assign ev_rep    = evt.start && match_q;
  assign ev_stp    = evt.stop && match_q;
  assign rd_sta    = i_rd && hit(i_addr, ISC_OFS_STA);

  // ****************************************************
  // bit-level slave state machine
  // ****************************************************
  // start and stop override any state so a confused master cannot lock us up
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      sh_q    <= 8'h00;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      ackph_q <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else if (!bus_on || evt.stop) begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
    end else if (evt.start) begin
      state_q <= ST_ADDR;
      cnt_q   <= 3'h0;
      oe_q    <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SKIP: begin
          oe_q <= 1'b0;               // wait for next condition
        end
        ST_ADDR: begin
          if (evt.scl_rise) begin
            sh_q  <= {sh_q[6:0], evt.sda};
            cnt_q <= cnt_q + 3'h1;
          end
          if (addr_done) begin
            rw_q    <= evt.sda;
            ackph_q <= 1'b0;
            ack_q   <= addr_hit && !ctl_q[ISC_C_NACK];
            state_q <= addr_hit ? ST_ACK : ST_SKIP;
          end
        end
        ST_ACK: begin
          if (evt.scl_fall && !ackph_q) begin
            oe_q    <= ack_q;         // hold data low for the ack bit
            ackph_q <= 1'b1;
          end else if (evt.scl_fall) begin
            cnt_q <= 3'h0;
            if (!ack_q) begin
              oe_q    <= 1'b0;
              state_q <= ST_SKIP;     // nacked: ignore rest of frame
            end else if (rw_q) begin
              sh_q    <= txd_q;
              oe_q    <= ~txd_q[7];
              state_q <= ST_TXB;
            end else begin
              oe_q    <= 1'b0;
              state_q <= ST_RXB;
            end
          end
        end
        ST_RXB: begin
          if (evt.scl_rise) begin
            sh_q  <= {sh_q[6:0], evt.sda};
            cnt_q <= cnt_q + 3'h1;
          end
          if (rx_done) begin
            ackph_q <= 1'b0;
            ack_q   <= !ctl_q[ISC_C_NACK];
            state_q <= ST_ACK;
          end
        end
        ST_TXB: begin
          if (evt.scl_fall && cnt_q == 3'(ISC_BITS_PER_BYTE - 1)) begin
            oe_q    <= 1'b0;          // release for master's ack bit
            state_q <= ST_TACK;
          end else if (evt.scl_fall) begin
            sh_q  <= {sh_q[6:0], 1'b0};
            oe_q  <= ~sh_q[6];
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_TACK: begin
          if (evt.scl_rise) begin
            mack_q <= ~evt.sda;       // low means master wants more
          end
          if (evt.scl_fall) begin
            cnt_q   <= 3'h0;
            sh_q    <= txd_q;
            oe_q    <= mack_q & ~txd_q[7];
            state_q <= mack_q ? ST_TXB : ST_SKIP;
          end
        end
      endcase
    end
  end

  // data output is open drain: level stays low, only enable moves
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sda_q <= 1'b0;
    end else begin
      sda_q <= 1'b0;
    end
  end

  // ****************************************************
  // software registers
  // ****************************************************
  // control: reserved bits kept as written, software keeps them zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_q <= ISC_RST_CTL;
    end else if (i_wr && hit(i_addr, ISC_OFS_CTL)) begin
      ctl_q <= i_wdata & ISC_CTL_WMASK;
    end
  end

  // mask and own address
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      msk_q <= ISC_RST_MSK;
      adr_q <= ISC_RST_ADR;
    end else if (i_wr) begin
      if (hit(i_addr, ISC_OFS_MSK)) begin
        msk_q <= i_wdata;
      end
      if (hit(i_addr, ISC_OFS_ADR)) begin
        adr_q <= i_wdata[6:0];
      end
    end
  end

  // transmit byte and receive byte
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txd_q <= ISC_RST_TXD;
      rxd_q <= 8'h00;
    end else begin
      if (i_wr && hit(i_addr, ISC_OFS_TXD)) begin
        txd_q <= i_wdata[7:0];
      end
      if (rx_done) begin
        rxd_q <= {sh_q[6:0], evt.sda};
      end
    end
  end

  // ****************************************************
  // status flags; a hardware set beats a clear
  // ****************************************************
  // matched start: dropped by any start or stop, raised on hit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      match_q <= 1'b0;
    end else if (!bus_on || evt.start || evt.stop) begin
      match_q <= 1'b0;
    end else if (addr_done && addr_hit) begin
      match_q <= 1'b1;
    end
  end

  // restart flag: read or stop clears it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rep_q <= 1'b0;
    end else if (ev_rep) begin
      rep_q <= 1'b1;
    end else if (rd_sta || evt.stop) begin
      rep_q <= 1'b0;
    end
  end

  // stop flag: status read clears it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stp_q <= 1'b0;
    end else if (ev_stp) begin
      stp_q <= 1'b1;
    end else if (rd_sta) begin
      stp_q <= 1'b0;
    end
  end

  // transmit request: default when a byte goes into the shifter, early at direction bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txr_q <= 1'b0;
    end else if (addr_done && addr_hit && evt.sda && ctl_q[ISC_C_EARLY]) begin
      txr_q <= 1'b1;
    end else if (tx_load) begin
      txr_q <= 1'b1;
    end else if (i_wr && hit(i_addr, ISC_OFS_TXD)) begin
      txr_q <= 1'b0;
    end
  end

  // receive request: byte waiting until the receive register is read
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxr_q <= 1'b0;
    end else if (rx_done) begin
      rxr_q <= 1'b1;
    end else if (i_rd && hit(i_addr, ISC_OFS_RXD)) begin
      rxr_q <= 1'b0;
    end
  end

  // ****************************************************
  // status assembly, interrupt and dma
  // ****************************************************
  always_comb begin
    sta_c              = 16'h0000;
    sta_c[ISC_S_START] = match_q;
    sta_c[ISC_S_REP]   = rep_q;
    sta_c[ISC_S_STOP]  = stp_q;
    sta_c[ISC_S_RXREQ] = rxr_q;
    sta_c[ISC_S_TXREQ] = txr_q;
    en_c               = 16'h0000;
    en_c[ISC_S_REP]    = ctl_q[ISC_C_IREP];
    en_c[ISC_S_TXREQ]  = ctl_q[ISC_C_ITX];
    en_c[ISC_S_RXREQ]  = ctl_q[ISC_C_IRX];
    en_c[ISC_S_STOP]   = ctl_q[ISC_C_ISTP];
  end

  // one level output; costs a cycle of latency but comes from a flop
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(sta_c & en_c & msk_q);
    end
  end

  // dma requests follow the pending flags while enabled
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txdma_q <= 1'b0;
      rxdma_q <= 1'b0;
    end else begin
      txdma_q <= txr_q && ctl_q[ISC_C_TXDMA];
      rxdma_q <= rxr_q && ctl_q[ISC_C_RXDMA];
    end
  end

  // ****************************************************
  // read port: data stand in the cycle after the strobe
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_q <= 16'h0000;
    end else if (i_rd) begin
      if (hit(i_addr, ISC_OFS_CTL)) begin
        rd_q <= ctl_q;
      end else if (hit(i_addr, ISC_OFS_STA)) begin
        rd_q <= sta_c;
      end else if (hit(i_addr, ISC_OFS_MSK)) begin
        rd_q <= msk_q;
      end else if (hit(i_addr, ISC_OFS_ADR)) begin
        rd_q <= {9'h000, adr_q};
      end else if (hit(i_addr, ISC_OFS_TXD)) begin
        rd_q <= {8'h00, txd_q};
      end else if (hit(i_addr, ISC_OFS_RXD)) begin
        rd_q <= {8'h00, rxd_q};
      end else begin
        rd_q <= 16'h0000;             // unmapped reads as zero
      end
    end else begin
      rd_q <= 16'h0000;
    end
  end

  assign o_rdata      = rd_q;
  assign o_sda        = sda_q;
  assign o_sda_oe     = oe_q;
  assign o_irq        = irq_q;
  assign o_tx_dma_req = txdma_q;
  assign o_rx_dma_req = rxdma_q;

endmodule : isc_slave_ctrl

// File: tb/isc_slave_ctrl_sva.sv
// assertion checker for the i2c slave control block
`timescale 1ns/1ps
module isc_slave_ctrl_sva (
  input wire logic                       i_clk,
  input wire logic                       i_resetn,
  input wire logic [isc_pkg::ISC_AW-1:0] i_addr,
  input wire logic [isc_pkg::ISC_DW-1:0] i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [isc_pkg::ISC_DW-1:0] o_rdata,
  input wire logic                       i_scl,
  input wire logic                       i_sda,
  input wire logic                       o_sda,
  input wire logic                       o_sda_oe,
  input wire logic                       o_irq,
  input wire logic                       o_tx_dma_req,
  input wire logic                       o_rx_dma_req
);
  import isc_pkg::*;
  // ************************
  // shadow state
  // ************************
  logic [15:0] ctl_q;  // copy of slave_control
  logic [15:0] msk_q;  // copy of interrupt mask
  logic [1:0]  pin_q;  // last clock and data samples
  logic        nk_q;   // refusal armed before a start
  logic [15:0] en_w;   // enables in status layout
  logic        gate_w; // some event can reach the line
  logic        map_w;  // address hits a register

  assign en_w = {2'b0, ctl_q[12], 2'b0, ctl_q[8], 6'b0, ctl_q[9], ctl_q[10], 2'b0};
  assign gate_w = |(en_w & msk_q);
  assign map_w = i_addr inside {ISC_OFS_CTL, ISC_OFS_STA, ISC_OFS_MSK, ISC_OFS_ADR, ISC_OFS_TXD, ISC_OFS_RXD};

  // control copy keeps only the writable bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) ctl_q <= ISC_RST_CTL;
    else if (i_wr && i_addr == ISC_OFS_CTL) ctl_q <= i_wdata & ISC_CTL_WMASK;
  end
  // mask copy
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) msk_q <= ISC_RST_MSK;
    else if (i_wr && i_addr == ISC_OFS_MSK) msk_q <= i_wdata;
  end
  // raw pin samples, idle bus is high
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) pin_q <= 2'b11;
    else pin_q <= {i_scl, i_sda};
  end
  // armed only when the refusal bit was set before the start came
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) nk_q <= 1'b0;
    else nk_q <= ctl_q[ISC_C_NACK] & (nk_q | (pin_q == 2'b11 && i_scl && !i_sda));
  end

  // ************************
  // properties
  // ************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd_ctl;
    i_rd && i_addr == ISC_OFS_CTL;
  endsequence
  sequence s_rd_unm;
    i_rd && !map_w;
  endsequence

  AST_TX_DMA: assert property (!$past(ctl_q[ISC_C_TXDMA]) |-> !o_tx_dma_req)
    else $error("tx dma request while disabled");
  AST_RX_DMA: assert property (!$past(ctl_q[ISC_C_RXDMA]) |-> !o_rx_dma_req)
    else $error("rx dma request while disabled");
  AST_IRQ_GATE: assert property (!$past(gate_w) |-> !o_irq)
    else $error("interrupt with no enabled event");
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_CTL_RB: assert property (s_rd_ctl |=> o_rdata == $past(ctl_q))
    else $error("control readback wrong");
  AST_UNMAP: assert property (s_rd_unm |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_OE_RISE: assert property ($rose(o_sda_oe) |-> !i_scl && o_sda == 1'b0)
    else $error("data pulled while clock high");
  AST_NACK: assert property (nk_q && $past(nk_q, 6) |-> !o_sda_oe)
    else $error("acknowledge while refusal set");
  AST_RST: assert property (disable iff (1'b0) !i_resetn |-> !o_irq && !o_sda_oe && !o_tx_dma_req)
    else $error("output active in reset");
endmodule : isc_slave_ctrl_sva

bind isc_slave_ctrl isc_slave_ctrl_sva u_sva (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_scl, .i_sda, .o_sda, .o_sda_oe, .o_irq, .o_tx_dma_req, .o_rx_dma_req);

// File: tb/isc_i2c_master.sv
// behavioural i2c bus master driving the slave's pins
`timescale 1ns/1ps
module isc_i2c_master (
  input  wire logic i_clk,     // paces the bus, 12 clocks a bit
  input  wire logic i_sda,     // resolved data line
  output logic      o_scl,     // serial clock, stands high between frames
  output logic      o_sda_low  // high while master pulls data low
);
  // ************************
  // bus primitives
  // ************************
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // wait n clocks
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tk
  // start or repeated start; data moves two clocks after the clock fall
  task automatic start();
    tk(2);
    o_sda_low <= 1'b0;
    tk(4);
    o_scl <= 1'b1;
    tk(6);
    o_sda_low <= 1'b1;
    tk(6);
    o_scl <= 1'b0;
  endtask : start
  // stop, then the line is left to the pull-up
  task automatic stop();
    tk(2);
    o_sda_low <= 1'b1;
    tk(4);
    o_scl <= 1'b1;
    tk(6);
    o_sda_low <= 1'b0;
    tk(6);
  endtask : stop
  // one bit; sampled at the end of the high phase
  task automatic clk_bit(input logic b, output logic r);
    tk(2);
    o_sda_low <= !b;
    tk(4);
    o_scl <= 1'b1;
    tk(6);
    r = i_sda;
    o_scl <= 1'b0;
  endtask : clk_bit
  // byte msb first plus the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
    clk_bit(ak, a);
  endtask : xfer
endmodule : isc_i2c_master

// File: tb/tb_isc_slave_ctrl.sv
// self-checking bench for the i2c slave control block
`timescale 1ns/1ps
module tb_isc_slave_ctrl;
  import isc_pkg::*;
  typedef struct {logic [31:0] a; logic [15:0] w; logic [15:0] r;} isc_row_s;
  logic        i_clk, i_resetn, i_wr, i_rd, i_scl, m_low;
  logic [31:0] i_addr;
  logic [15:0] i_wdata, o_rdata, v;
  logic        o_sda, o_sda_oe, o_irq, o_tx_dma_req, o_rx_dma_req, a;
  logic [7:0]  q;
  wire         i_sda = !(m_low | (o_sda_oe & !o_sda));  // pull-up line, slave side open drain
  int          n_mismatch = 0;
  int          n_compared = 0;
  // write, read back, expected; bit 6 written zero to control
  isc_row_s rows [4] = '{'{ISC_OFS_CTL, 16'hFFBF, 16'h7FAF}, '{ISC_OFS_CTL, 16'h0000, 16'h0000},
                         '{32'h40003440, 16'hFFFF, 16'h0000}, '{32'h40003424, 16'hFFFF, 16'h0000}};

  isc_slave_ctrl dut (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_scl, .i_sda,
    .o_sda, .o_sda_oe, .o_irq, .o_tx_dma_req, .o_rx_dma_req);
  isc_i2c_master m (.i_clk, .i_sda, .o_scl(i_scl), .o_sda_low(m_low));

  always #2 i_clk = ~i_clk;

  // ************************
  // helpers
  // ************************
  task automatic wr(input logic [31:0] ad, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] ad, output logic [15:0] d);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic settle();
    repeat (5) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_b(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask : chk_b
  // address byte; dma request looked at before the acknowledge slot
  task automatic adr(input logic [7:0] b, input logic e, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) m.clk_bit(b[i], r);
    repeat (3) @(posedge i_clk);
    #1 chk_b(o_tx_dma_req, e);
    m.clk_bit(1'b1, ak);
  endtask : adr
  task automatic end_of_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // ************************
  // sequence
  // ************************
  initial begin
    {i_clk, i_resetn, i_wr, i_rd, i_addr, i_wdata} = '0;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(ISC_OFS_CTL, v);
    chk_w(v, ISC_RST_CTL);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a, v);
      chk_w(v, rows[k].r);
    end
    // write with rx dma, rx and stop interrupts on
    wr(ISC_OFS_ADR, 16'h002A);
    wr(ISC_OFS_MSK, 16'h240C);
    wr(ISC_OFS_CTL, 16'h2301);
    m.start();
    adr(8'h54, 1'b0, a);
    chk_b(a, 1'b0);
    m.xfer(8'hA5, 1'b1, q, a);
    settle();
    chk_b(o_rx_dma_req, 1'b1);
    chk_b(o_irq, 1'b1);
    rd(ISC_OFS_RXD, v);
    chk_w(v, 16'h00A5);
    settle();
    chk_b(o_irq, 1'b0);
    m.stop();
    settle();
    chk_b(o_irq, 1'b1);
    rd(ISC_OFS_STA, v);
    chk_w(v & 16'h0400, 16'h0400);
    settle();
    chk_b(o_irq, 1'b0);
    // same traffic with every dma and interrupt enable off
    wr(ISC_OFS_CTL, 16'h0001);
    m.start();
    adr(8'h54, 1'b0, a);
    m.xfer(8'h5A, 1'b1, q, a);
    settle();
    chk_b(o_rx_dma_req, 1'b0);
    chk_b(o_irq, 1'b0);
    m.stop();
    settle();
    chk_b(o_irq, 1'b0);
    rd(ISC_OFS_RXD, v);
    rd(ISC_OFS_STA, v);
    // reads: default then early request timing
    for (int e = 0; e < 2; e++) begin
      wr(ISC_OFS_TXD, 16'h003C + 16'(e));
      wr(ISC_OFS_CTL, e ? 16'h4021 : 16'h4401);
      m.start();
      adr(8'h55, e[0], a);
      settle();
      chk_b(o_tx_dma_req, 1'b1);
      chk_b(o_irq, !e[0]);
      m.xfer(8'hFF, 1'b1, q, a);
      chk_w({8'h00, q}, 16'h003C + 16'(e));
      m.stop();
    end
    wr(ISC_OFS_TXD, 16'h0000);
    rd(ISC_OFS_STA, v);
    // repeated start while matched
    wr(ISC_OFS_CTL, 16'h1001);
    m.start();
    adr(8'h54, 1'b0, a);
    m.start();
    adr(8'h54, 1'b0, a);
    settle();
    chk_b(o_irq, 1'b1);
    rd(ISC_OFS_STA, v);
    chk_w(v & 16'h2000, 16'h2000);
    rd(ISC_OFS_STA, v);
    chk_w(v & 16'h2000, 16'h0000);
    m.stop();
    // refusal of the next transfer
    wr(ISC_OFS_CTL, 16'h0081);
    m.start();
    adr(8'h54, 1'b0, a);
    chk_b(a, 1'b1);
    m.stop();
    // second reset in mid-run
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(ISC_OFS_CTL, v);
    chk_w(v, ISC_RST_CTL);
    end_of_test();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_isc_slave_ctrl
